// ### logic/charger_id_pkg.sv
// Package with constants and types for the control identity register
package charger_id_pkg;
  localparam logic [7:0] REG_OFFSET = 8'h14;
  localparam int RESET_BIT = 7;
  localparam int DONE_BIT = 6;
  localparam logic [2:0] CFG_CODE_DEFAULT = 3'h5; // Arbitrary value
  localparam logic THERMAL_DEFAULT = 1'b1;
  localparam logic [1:0] REV_CODE_DEFAULT = 2'h2; // Arbitrary value
  localparam int RESTORE_CYCLES = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  typedef struct packed {
    logic restore;
    logic timer_restart;
  } restore_cmd_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RESTORE = 2'b01,
    ST_DONE = 2'b10
  } restore_state_type;
endpackage

// ### logic/restore_timer.sv
// Counter that times the register restoration
`timescale 1ns/1ns
module restore_timer
  import charger_id_pkg::*;
#(
  parameter int CYCLES = RESTORE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic start,
  output logic busy_ff
);
  logic [7:0] cnt_ff;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= 8'h00;
      busy_ff <= 1'b0;
    end else if (start) begin
      cnt_ff <= 8'(CYCLES - 1);
      busy_ff <= 1'b1;
    end else if (cnt_ff != 8'h00) begin
      cnt_ff <= cnt_ff - 8'h01;
    end else begin
      busy_ff <= 1'b0;
    end
  end
endmodule

// ### logic/charger_control_identity_register.sv
// Control, status and identity register of the charge controller
`timescale 1ns/1ns
//------------------------------------------------------------
// Notes on behaviour
// RULE_01: Writing one to bit 7 restores and restarts
// RULE_02: Reset bit clears itself after restoration
// RULE_03: Writing zero to bit 7 changes nothing
// RULE_04: Bit 6 reads optimiser done status
// RULE_05: Bits 5..0 fixed identity codes, writes ignored
//------------------------------------------------------------
module charger_control_identity_register
  import charger_id_pkg::*;
#(
  parameter logic [2:0] CFG_CODE = CFG_CODE_DEFAULT, // Arbitrary value
  parameter logic [1:0] REV_CODE = REV_CODE_DEFAULT, // Arbitrary value
  parameter logic THERMAL = THERMAL_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic optimiser_done_flag,
  output logic [7:0] reg_rdata_ff,
  output logic rdata_valid_ff,
  output logic restore_defaults_ff,
  output logic safety_timer_restart_ff
);
  //------------------------------------------------------------
  // Restoration sequence
  //------------------------------------------------------------
  restore_state_type state_ff;
  restore_state_type nxt_state;
  logic reset_req_ff;
  logic done_sync_ff;
  logic busy;
  logic hit;
  logic start;
  logic zero_write;
  restore_cmd_type nxt_cmd;
  logic [7:0] nxt_rdata;

  //------------------------------------------------------------
  // Write decode
  //------------------------------------------------------------
  // Only bit 7 of a write is acted on; the other bits are read only
  assign hit = (reg_addr == REG_OFFSET);
  assign start = reg_wr && hit && reg_wdata[RESET_BIT]; // RULE_01
  // A write with bit 7 low is accepted and has no effect
  assign zero_write = reg_wr && hit && !reg_wdata[RESET_BIT]; // RULE_03

  restore_timer #(.CYCLES(RESTORE_CYCLES)) u_timer (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .start(start),
    .busy_ff(busy)
  );

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start) begin
          nxt_state = ST_RESTORE; // RULE_01
        end
      end
      ST_RESTORE: begin
        if (!busy && !start) begin
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: begin
        nxt_state = start ? ST_RESTORE : ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Request bit held until restoration completes; zero writes ignored
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reset_req_ff <= 1'b0;
    end else if (start) begin
      reset_req_ff <= 1'b1; // RULE_01
    end else if (state_ff == ST_DONE) begin
      reset_req_ff <= 1'b0; // RULE_02
    end
  end // RULE_03

  // Both pulses come from one command word so they never skew
  always_comb begin
    nxt_cmd = '{restore: 1'b0, timer_restart: 1'b0};
    if (start) begin
      nxt_cmd.restore = 1'b1; // RULE_01
      nxt_cmd.timer_restart = 1'b1; // RULE_01
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      restore_defaults_ff <= 1'b0;
      safety_timer_restart_ff <= 1'b0;
    end else begin
      restore_defaults_ff <= nxt_cmd.restore; // RULE_01
      safety_timer_restart_ff <= nxt_cmd.timer_restart; // RULE_01
    end
  end

  //------------------------------------------------------------
  // Read path
  //------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      done_sync_ff <= 1'b0;
    end else begin
      done_sync_ff <= optimiser_done_flag; // RULE_04
    end
  end

  // Read word; other addresses read as zero
  always_comb begin
    nxt_rdata = 8'h00;
    if (hit) begin
      nxt_rdata[RESET_BIT] = reset_req_ff; // RULE_02
      nxt_rdata[DONE_BIT] = done_sync_ff; // RULE_04
      nxt_rdata[5:0] = {CFG_CODE, THERMAL, REV_CODE}; // RULE_05
    end
  end

  // Read data stays put until the next read strobe
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_ff <= CTRL_RESET;
      rdata_valid_ff <= 1'b0;
    end else begin
      rdata_valid_ff <= reg_rd;
      if (reg_rd) begin
        reg_rdata_ff <= nxt_rdata;
      end
    end
  end

  //------------------------------------------------------------
  // Checks
  //------------------------------------------------------------
  // Restore command and pulses
  a_write_starts: assert property ( // RULE_01
    @(posedge clk_sys) disable iff (!rstn)
    start |=> restore_defaults_ff && safety_timer_restart_ff)
    else $error("reset write did not restore");
  a_pulse_pair: assert property ( // RULE_01
    @(posedge clk_sys) disable iff (!rstn)
    restore_defaults_ff == safety_timer_restart_ff)
    else $error("restore and timer pulses differ");
  a_zero_write: assert property ( // RULE_03
    @(posedge clk_sys) disable iff (!rstn)
    reg_wr && !start |=> !restore_defaults_ff)
    else $error("zero write caused restore");
  a_zero_timer: assert property ( // RULE_03
    @(posedge clk_sys) disable iff (!rstn)
    zero_write |=> !safety_timer_restart_ff)
    else $error("zero write restarted timer");
  a_idle_quiet: assert property ( // RULE_03
    @(posedge clk_sys) disable iff (!rstn)
    !start |=> !restore_defaults_ff && !safety_timer_restart_ff)
    else $error("restore pulse without request");
  // Self clearing request bit
  a_req_set: assert property ( // RULE_01
    @(posedge clk_sys) disable iff (!rstn)
    start |=> reset_req_ff)
    else $error("request bit not set");
  a_req_held: assert property ( // RULE_02
    @(posedge clk_sys) disable iff (!rstn)
    reset_req_ff && state_ff != ST_DONE |=> reset_req_ff)
    else $error("request bit dropped early");
  a_req_clear: assert property ( // RULE_02
    @(posedge clk_sys) disable iff (!rstn)
    state_ff == ST_DONE && !start |=> !reset_req_ff)
    else $error("request bit kept after restore");
  a_self_clear: assert property ( // RULE_02
    @(posedge clk_sys) disable iff (!rstn)
    start ##1 !start [*8] |=> !reset_req_ff)
    else $error("reset bit did not self clear");
  a_restore_ends: assert property ( // RULE_02
    @(posedge clk_sys) disable iff (!rstn)
    start ##1 !start [*8] |=> state_ff == ST_IDLE)
    else $error("restore sequence did not end");
  a_zero_keeps: assert property ( // RULE_03
    @(posedge clk_sys) disable iff (!rstn)
    zero_write && state_ff != ST_DONE |=>
      reset_req_ff == $past(reset_req_ff))
    else $error("zero write changed request bit");
  // Read port
  a_done_read: assert property ( // RULE_04
    @(posedge clk_sys) disable iff (!rstn)
    reg_rd && hit |=>
      reg_rdata_ff[DONE_BIT] == $past(done_sync_ff))
    else $error("done bit wrong");
  a_fixed_bits: assert property ( // RULE_05
    @(posedge clk_sys) disable iff (!rstn)
    reg_rd && hit |=>
      reg_rdata_ff[5:0] == {CFG_CODE, THERMAL, REV_CODE})
    else $error("identity bits wrong");
  a_other_zero: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    reg_rd && !hit |=> reg_rdata_ff == 8'h00)
    else $error("other address read not zero");
  a_valid_pulse: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    reg_rd |=> rdata_valid_ff)
    else $error("read valid missing");
  a_valid_quiet: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    !reg_rd |=> !rdata_valid_ff)
    else $error("read valid without read");
  a_rdata_holds: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    !reg_rd |=> $stable(reg_rdata_ff))
    else $error("read data changed without read");
endmodule

// ### bench/test_charger_control_identity_register.sv
// Testbench for the control identity register
`timescale 1ns/1ns
module test_charger_control_identity_register
  import charger_id_pkg::*;
;
  localparam logic [7:0] ID_VAL =
    {2'h0, CFG_CODE_DEFAULT, THERMAL_DEFAULT, REV_CODE_DEFAULT};
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic optimiser_done_flag = 1'b0;
  logic [7:0] reg_rdata_ff;
  logic rdata_valid_ff;
  logic restore_defaults_ff;
  logic safety_timer_restart_ff;
  int fail_count = 0;
  int checks_done = 0;
  int cycle_count = 0;

  charger_control_identity_register dut (
    .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .optimiser_done_flag(optimiser_done_flag),
    .reg_rdata_ff(reg_rdata_ff), .rdata_valid_ff(rdata_valid_ff),
    .restore_defaults_ff(restore_defaults_ff),
    .safety_timer_restart_ff(safety_timer_restart_ff));

  //----------------------------------------
  // Clock and hang guard
  //----------------------------------------
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycle_count++;
    if (cycle_count == 2000) begin
      fail_count++;
      finish_test();
    end
  end

  //----------------------------------------
  // Bus tasks
  //----------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    check({7'h00, rdata_valid_ff}, 8'h01);
    check(reg_rdata_ff, exp);
  endtask

  // Both pulses are seen for exactly one cycle after the write when pulse is set, and stay low when it is clear
  task automatic wr(input logic [7:0] d, input logic pulse);
    @(negedge clk_sys);
    reg_addr = REG_OFFSET;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    check({6'h00, restore_defaults_ff, safety_timer_restart_ff},
          {6'h00, pulse, pulse});
    @(negedge clk_sys);
    check({6'h00, restore_defaults_ff, safety_timer_restart_ff}, 8'h00);
  endtask

  //----------------------------------------
  // Scenarios
  //----------------------------------------
  task automatic test_identity();
    check(reg_rdata_ff, CTRL_RESET);
    check({6'h00, restore_defaults_ff, rdata_valid_ff}, 8'h00);
    rd(REG_OFFSET, ID_VAL);
    rd(8'h13, 8'h00);
    $display("identity test done");
  endtask

  task automatic test_done_flag();
    @(negedge clk_sys);
    optimiser_done_flag = 1'b1;
    repeat (2) @(negedge clk_sys);
    rd(REG_OFFSET, ID_VAL | 8'h40);
    optimiser_done_flag = 1'b0;
    repeat (2) @(negedge clk_sys);
    rd(REG_OFFSET, ID_VAL);
    $display("optimiser flag test done");
  endtask

  task automatic test_restore();
    wr(8'hFF, 1'b1);
    rd(REG_OFFSET, ID_VAL | 8'h80);
    repeat (RESTORE_CYCLES + 4) @(negedge clk_sys);
    rd(REG_OFFSET, ID_VAL);
    wr(8'h80, 1'b1);
    wr(8'h80, 1'b1);
    repeat (RESTORE_CYCLES + 4) @(negedge clk_sys);
    rd(REG_OFFSET, ID_VAL);
    $display("restore test done");
  endtask

  task automatic test_zero_write();
    wr(8'h7F, 1'b0);
    rd(REG_OFFSET, ID_VAL);
    $display("zero write test done");
  endtask

  // Reset in mid restoration drops the request bit
  task automatic test_mid_reset();
    wr(8'h80, 1'b1);
    @(negedge clk_sys);
    rstn = 1'b0;
    @(negedge clk_sys);
    check({6'h00, restore_defaults_ff, rdata_valid_ff}, 8'h00);
    check(reg_rdata_ff, CTRL_RESET);
    rstn = 1'b1;
    rd(REG_OFFSET, ID_VAL);
    $display("mid run reset test done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(negedge clk_sys);
    rstn = 1'b1;
    test_identity();
    test_done_flag();
    test_restore();
    test_zero_write();
    test_mid_reset();
    finish_test();
  end
endmodule
